// *** ndb_defs.vh ***
// Constants for the nibble data buffer transfer block
`ifndef NDB_DEFS_VH
`define NDB_DEFS_VH
`define NDB_ADDR_NIB_HIGH      4'hC
`define NDB_ADDR_NIB_UMID      4'hD
`define NDB_ADDR_NIB_LMID      4'hE
`define NDB_ADDR_NIB_LOW       4'hF
`define NDB_PADDR_SERIAL       7'h01
`define NDB_PADDR_TMR0_MODE    7'h02
`define NDB_PADDR_TMR1_MODE    7'h03
`define NDB_PADDR_CONV_RESULT  7'h04
`define NDB_PADDR_TABLE_PTR    7'h40
`define NDB_PADDR_TMR_COUNT    7'h45
`define NDB_TPTR_WIDTH         11
`define NDB_BUF_RESET          16'h0000
`define NDB_TPTR_RESET         11'h000
`define NDB_BYTE_RESET         8'h00
`define NDB_OP_NONE            2'h0
`define NDB_OP_GET             2'h1
`define NDB_OP_PUT             2'h2
`define NDB_OP_TABLE_READ_INSTR            2'h3
`endif

// *** ndb_xfer.v ***
// Nibble data buffer with peripheral and table transfer logic
`timescale 1ns/10ps
`include "ndb_defs.vh"

// Summary of operation
// - Buffer is four nibbles at data addresses 0CH to 0FH in bank zero.
// - Buffer bit 0 is bit 0 of 0FH; bit 15 is bit 3 of 0CH.
// - Data memory instructions read and write buffer nibbles directly.
// - Peripheral read copies the addressed peripheral's data into the buffer.
// - Peripheral write delivers buffer contents to the addressed peripheral.
// - Reading a write-only peripheral loads an undefined value.
// - Writing a read-only peripheral changes nothing, like a no-operation.
// - 01H serial, 02H/03H timer modes write only, 04H converter result.
// - 40H is the table pointer, 16-bit read and write, 10 or 11 bits.
// - 45H is the timer count pair, 16-bit read only; writes ignored.
// - Peripheral reads and writes take one cycle whatever their width.
// - Writes to 8-bit peripherals use only the low buffer byte.
// - Reads from 8-bit peripherals leave the upper two nibbles unchanged.
// - Table read loads the program word at the table pointer into the buffer.
module ndb_xfer #(
	parameter TPTR_BITS = `NDB_TPTR_WIDTH
) (
	input  wire                     sys_clk,
	input  wire                     nrst,
	input  wire                     dm_wr,
	input  wire [3:0]               dm_addr,
	input  wire                     dm_bank_zero,
	input  wire [3:0]               dm_wdata,
	input  wire [1:0]               op,
	input  wire [6:0]               periph_addr,
	input  wire [7:0]               serial_shift_rdata,
	input  wire [7:0]               converter_result_rdata,
	input  wire [15:0]              timer_count_pair,
	input  wire [15:0]              rom_rdata,
	output reg  [3:0]               dm_rdata,
	output reg                      dm_hit,
	output reg  [15:0]              transfer_buffer,
	output reg  [TPTR_BITS-1:0]     table_pointer_register,
	output reg  [7:0]               first_timer_mode_register,
	output reg  [7:0]               second_timer_mode_register,
	output reg  [7:0]               serial_shift_wdata,
	output reg                      serial_shift_wr,
	output reg  [7:0]               converter_result_wdata,
	output reg                      converter_result_wr,
	output reg  [TPTR_BITS-1:0]     rom_addr,
	output reg                      xfer_done
);

	reg [15:0] buf_d;
	reg [3:0]  rd_nib;
	reg        hit;

	// Nibble index 0 is the least significant one at 0FH
	function [1:0] nib_idx;
		input [3:0] a;
		begin
			nib_idx = 2'h3 - a[1:0];
		end
	endfunction

	function is_buf_addr;
		input [3:0] a;
		input       memory_bank_zero;
		begin
			is_buf_addr = memory_bank_zero && (a[3:2] == `NDB_ADDR_NIB_HIGH >> 2);
		end
	endfunction

	always @* begin
		hit = is_buf_addr(dm_addr, dm_bank_zero);
		case (nib_idx(dm_addr))
			2'h0: rd_nib = transfer_buffer[3:0];
			2'h1: rd_nib = transfer_buffer[7:4];
			2'h2: rd_nib = transfer_buffer[11:8];
			default: rd_nib = transfer_buffer[15:12];
		endcase
	end

	always @* begin
		buf_d = transfer_buffer;
		if (dm_wr && hit) begin
			case (nib_idx(dm_addr))
				2'h0: buf_d[3:0] = dm_wdata;
				2'h1: buf_d[7:4] = dm_wdata;
				2'h2: buf_d[11:8] = dm_wdata;
				default: buf_d[15:12] = dm_wdata;
			endcase
		end
		case (op)
			`NDB_OP_GET: begin
				case (periph_addr)
					`NDB_PADDR_SERIAL: buf_d[7:0] = serial_shift_rdata;
					`NDB_PADDR_CONV_RESULT: buf_d[7:0] = converter_result_rdata;
					// Undefined read: return zeros in the low byte
					`NDB_PADDR_TMR0_MODE: buf_d[7:0] = `NDB_BYTE_RESET;
					`NDB_PADDR_TMR1_MODE: buf_d[7:0] = `NDB_BYTE_RESET;
					`NDB_PADDR_TABLE_PTR: buf_d = {{(16-TPTR_BITS){1'b0}},
						table_pointer_register};
					`NDB_PADDR_TMR_COUNT: buf_d = timer_count_pair;
					// Unknown address: keep any nibble write of this cycle
					default: buf_d = buf_d;
				endcase
			end
			`NDB_OP_TABLE_READ_INSTR: buf_d = rom_rdata;
			default: buf_d = buf_d;
		endcase
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			transfer_buffer            <= `NDB_BUF_RESET;
			table_pointer_register     <= `NDB_TPTR_RESET;
			first_timer_mode_register  <= `NDB_BYTE_RESET;
			second_timer_mode_register <= `NDB_BYTE_RESET;
			serial_shift_wdata         <= `NDB_BYTE_RESET;
			serial_shift_wr            <= 1'b0;
			converter_result_wdata     <= `NDB_BYTE_RESET;
			converter_result_wr        <= 1'b0;
			rom_addr                   <= `NDB_TPTR_RESET;
			dm_rdata                   <= 4'h0;
			dm_hit                     <= 1'b0;
			xfer_done                  <= 1'b0;
		end else begin
			transfer_buffer     <= buf_d;
			dm_rdata            <= rd_nib;
			dm_hit              <= hit;
			serial_shift_wr     <= 1'b0;
			converter_result_wr <= 1'b0;
			// Every transfer completes in one cycle regardless of width
			xfer_done           <= (op != `NDB_OP_NONE);
			rom_addr            <= table_pointer_register;
			if (op == `NDB_OP_PUT) begin
				case (periph_addr)
					`NDB_PADDR_SERIAL: begin
						serial_shift_wdata <= transfer_buffer[7:0];
						serial_shift_wr    <= 1'b1;
					end
					`NDB_PADDR_TMR0_MODE: first_timer_mode_register <= transfer_buffer[7:0];
					`NDB_PADDR_TMR1_MODE: second_timer_mode_register <= transfer_buffer[7:0];
					`NDB_PADDR_CONV_RESULT: begin
						converter_result_wdata <= transfer_buffer[7:0];
						converter_result_wr    <= 1'b1;
					end
					`NDB_PADDR_TABLE_PTR:
						table_pointer_register <= transfer_buffer[TPTR_BITS-1:0];
					// Count pair and unknown addresses are read only: no state changes
					default: table_pointer_register <= table_pointer_register;
				endcase
			end
		end
	end

endmodule

// *** ndb_props.sv ***
// Port assertions for the buffer transfer block
`timescale 1ns/10ps
module ndb_props (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        dm_wr,
	input wire logic [1:0]  op,
	input wire logic [6:0]  periph_addr,
	input wire logic [7:0]  serial_shift_rdata,
	input wire logic [15:0] timer_count_pair,
	input wire logic [15:0] rom_rdata,
	input wire logic [15:0] transfer_buffer,
	input wire logic [7:0]  serial_shift_wdata,
	input wire logic        serial_shift_wr,
	input wire logic [7:0]  converter_result_wdata,
	input wire logic        converter_result_wr,
	input wire logic [7:0]  first_timer_mode_register,
	input wire logic [10:0] table_pointer_register,
	input wire logic        xfer_done
);
	wire rd = op == 2'h1;
	wire wr = op == 2'h2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_get_serial: assert property (rd && periph_addr == 7'h01 |=>
		transfer_buffer[7:0] == $past(serial_shift_rdata)) else $error("serial read wrong");
	a_keep_upper: assert property (rd && periph_addr == 7'h01 && !dm_wr |=>
		$stable(transfer_buffer[15:8])) else $error("upper byte changed");
	a_put_serial: assert property (wr && periph_addr == 7'h01 |=> serial_shift_wr &&
		serial_shift_wdata == $past(transfer_buffer[7:0])) else $error("serial write wrong");
	a_put_count: assert property (wr && periph_addr == 7'h45 && !dm_wr |=>
		$stable(transfer_buffer) && !serial_shift_wr) else $error("read-only write acted");
	a_table_load: assert property (op == 2'h3 |=>
		transfer_buffer == $past(rom_rdata)) else $error("table read wrong");
	a_get_count: assert property (rd && periph_addr == 7'h45 |=>
		transfer_buffer == $past(timer_count_pair)) else $error("count read wrong");
	a_done_pulse: assert property (op != 2'h0 |=> xfer_done) else $error("no done");
	a_idle_hold: assert property (op == 2'h0 && !dm_wr |=>
		$stable(transfer_buffer) && !xfer_done) else $error("idle buffer changed");
	a_put_conv: assert property (wr && periph_addr == 7'h04 |=> converter_result_wr &&
		converter_result_wdata == $past(transfer_buffer[7:0])) else $error("converter write wrong");
	a_put_mode: assert property (wr && periph_addr == 7'h02 |=>
		first_timer_mode_register == $past(transfer_buffer[7:0])) else $error("mode write wrong");
	a_put_pointer: assert property (wr && periph_addr == 7'h40 |=>
		table_pointer_register == $past(transfer_buffer[10:0])) else $error("pointer write wrong");
endmodule
bind ndb_xfer ndb_props i_ndb_props (.*);

// *** ndb_periph.sv ***
// Peripheral and program memory model beside the buffer block
`timescale 1ns/10ps
module ndb_periph (
	input  wire logic        sys_clk,
	input  wire logic        serial_shift_wr,
	input  wire logic [7:0]  serial_shift_wdata,
	input  wire logic [10:0] table_pointer_register,
	output var  logic [7:0]  serial_shift_rdata = 8'h5A,
	output wire logic [7:0]  converter_result_rdata,
	output wire logic [15:0] timer_count_pair,
	output wire logic [15:0] rom_rdata
);
	always @(posedge sys_clk) if (serial_shift_wr) serial_shift_rdata <= serial_shift_wdata;
	assign converter_result_rdata = 8'h96;
	assign timer_count_pair = 16'hC3A7;
	// Word tracks the address so a stale pointer shows
	assign rom_rdata = {5'h15, table_pointer_register};
endmodule

// *** tb_top.sv ***
// Testbench for the buffer transfer block
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	logic sys_clk = 0, nrst = 0, dm_wr = 0, dm_bank_zero = 1, dm_hit, xfer_done;
	logic serial_shift_wr, converter_result_wr;
	logic [1:0] op = 0;
	logic [3:0] dm_addr = 0, dm_wdata = 0, dm_rdata;
	logic [6:0] periph_addr = 0;
	logic [7:0] serial_shift_rdata, converter_result_rdata, first_timer_mode_register;
	logic [7:0] second_timer_mode_register, serial_shift_wdata, converter_result_wdata;
	logic [10:0] table_pointer_register, rom_addr;
	logic [15:0] timer_count_pair, rom_rdata, transfer_buffer;
	int bad_count = 0, total_checks = 0, cyc = 0;
	ndb_xfer i_ndb_xfer (.*);
	ndb_periph i_ndb_periph (.*);
	initial forever #5 sys_clk = ~sys_clk;
	task end_sim;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) if (++cyc == 500) begin bad_count++; end_sim; end
	task xo(input [1:0] o, input [6:0] a);
		@(posedge sys_clk) begin op <= o; periph_addr <= a; end
		@(posedge sys_clk) op <= 2'h0;
		#1 `CHK("done", 1'b1, xfer_done)
	endtask
	task nw(input b, input [3:0] a, input [3:0] d);
		@(posedge sys_clk) begin dm_wr <= 1; dm_bank_zero <= b; dm_addr <= a; dm_wdata <= d; end
		@(posedge sys_clk) dm_wr <= 0;
		#1;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1;
		for (int i = 0; i < 4; i++) nw(1, 4'hC + i[3:0], i[3:0] + 4'h1);
		@(posedge sys_clk) #1 `CHK("nibble", 5'h14, {dm_hit, dm_rdata})
		nw(0, 4'hF, 4'h9);
		`CHK("buffer", 16'h1234, transfer_buffer)
		`CHK("bank miss", 1'b0, dm_hit)
		$display("test nibble access done");
		xo(2'h1, 7'h01);
		`CHK("get serial", 16'h125A, transfer_buffer)
		xo(2'h2, 7'h02);
		xo(2'h2, 7'h03);
		`CHK("modes", 16'h5A5A, {first_timer_mode_register, second_timer_mode_register})
		xo(2'h2, 7'h01);
		`CHK("put serial", 9'h15A, {serial_shift_wr, serial_shift_wdata})
		xo(2'h1, 7'h02);
		`CHK("get wronly", 16'h1200, transfer_buffer)
		xo(2'h1, 7'h04);
		`CHK("get conv", 16'h1296, transfer_buffer)
		xo(2'h2, 7'h04);
		`CHK("put conv", 9'h196, {converter_result_wr, converter_result_wdata})
		xo(2'h2, 7'h40);
		xo(2'h1, 7'h40);
		`CHK("pointer", 16'h0296, transfer_buffer)
		xo(2'h2, 7'h45);
		`CHK("put rdonly", 11'h296, table_pointer_register)
		xo(2'h1, 7'h45);
		`CHK("count", 16'hC3A7, transfer_buffer)
		xo(2'h3, 7'h00);
		`CHK("table", {5'h15, 11'h296}, transfer_buffer)
		`CHK("rom addr", 11'h296, rom_addr)
		@(posedge sys_clk) begin
			dm_wr <= 1; dm_bank_zero <= 1; dm_addr <= 4'hC; dm_wdata <= 4'h7;
			op <= 2'h1; periph_addr <= 7'h10;
		end
		@(posedge sys_clk) begin dm_wr <= 0; op <= 2'h0; end
		#1 `CHK("write on miss", {4'h7, 1'b1, 11'h296}, transfer_buffer)
		$display("test peripheral transfers done");
		end_sim;
	end
endmodule
